// >>> verilog/qdac_consts.svh
// constants for the quad converter serial command link
`ifndef QDAC_CONSTS_SVH
`define QDAC_CONSTS_SVH
`define QDAC_WORD_BITS 32
`define QDAC_CMD_MSB 23
`define QDAC_CMD_LSB 20
`define QDAC_ADDR_MSB 19
`define QDAC_ADDR_LSB 16
`define QDAC_DATA_MSB 15
`define QDAC_DATA_LSB 4
`define QDAC_CMD_UPDATE 4'h3
`define QDAC_ADDR_ALL 4'hf
`define QDAC_NUM_CH 4
`define QDAC_DIV_HALF 8'h01
`define QDAC_REG_CTRL 12'h000
`define QDAC_REG_TXWORD 12'h004
`define QDAC_REG_STATUS 12'h008
`define QDAC_REG_ECHO 12'h00c
`define QDAC_CTRL_START 0
`define QDAC_CTRL_CLEAR 1
`define QDAC_STAT_BUSY 0
`define QDAC_STAT_DONE 1
`define QDAC_STAT_ECHO_OK 2
`endif

// >>> verilog/qdac_pkg.sv
// types for the quad converter serial command link
package qdac_pkg;
    typedef enum logic [1:0] {
        QDAC_IDLE = 2'b00,
        QDAC_LOW = 2'b01,
        QDAC_HIGH = 2'b10,
        QDAC_END = 2'b11
    } qdac_mst_state_t;
endpackage : qdac_pkg

// >>> verilog/qdac_link_if.sv
// link wires between the command master and the quad converter
`timescale 1ns/10ps
interface qdac_link_if;
    logic serial_clk;
    logic mosi;
    logic miso;
    logic converter_select_n;
    logic converter_clear_n;
    logic serial_flash_select_n;
    logic preamp_select_n;
    logic adc_convert_strobe;
    logic parallel_flash_chip_enable_n;
    logic config_prom_init_n;
    modport master (
        output serial_clk,
        output mosi,
        input miso,
        output converter_select_n,
        output converter_clear_n,
        output serial_flash_select_n,
        output preamp_select_n,
        output adc_convert_strobe,
        output parallel_flash_chip_enable_n,
        output config_prom_init_n
    );
    modport converter (
        input serial_clk,
        input mosi,
        output miso,
        input converter_select_n,
        input converter_clear_n
    );
endinterface : qdac_link_if

// >>> verilog/qdac_sync.sv
// two flip-flop level synchroniser
`timescale 1ns/10ps
module qdac_sync #(
    parameter int WIDTH = 1
) (
    input wire logic clk,
    input wire logic rst_n,
    input wire logic [WIDTH-1:0] d,
    output logic [WIDTH-1:0] q
);
    logic [WIDTH-1:0] meta_r;
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            meta_r <= '0;
            q <= '0;
        end else begin
            meta_r <= d;
            q <= meta_r;
        end
    end
endmodule : qdac_sync

// >>> verilog/qdac_converter.sv
// converter end: 32-bit shift register, echo and four output latches
`timescale 1ns/10ps
`include "qdac_consts.svh"
module qdac_converter #(
    parameter int CH_BITS = 12
) (
    qdac_link_if.converter link,
    output logic [CH_BITS-1:0] ch_a,
    output logic [CH_BITS-1:0] ch_b,
    output logic [CH_BITS-1:0] ch_c,
    output logic [CH_BITS-1:0] ch_d,
    output logic conv_start
);
    logic [31:0] shift_r;
    logic [31:0] echo_r;
    logic [31:0] rx_w;
    logic miso_r;
    logic [CH_BITS-1:0] ch_r [`QDAC_NUM_CH];
    logic conv_r;

    // rising edge: sample mosi only while selected
    always_ff @(posedge link.serial_clk or negedge link.converter_clear_n)
    begin
        if (!link.converter_clear_n) begin
            shift_r <= 32'h00000000;
        end else if (!link.converter_select_n) begin
            shift_r <= {shift_r[30:0], link.mosi};
        end
    end

    // falling edge: present previous word msb first
    logic [4:0] tx_cnt_r;
    always_ff @(negedge link.serial_clk or negedge link.converter_clear_n)
    begin
        if (!link.converter_clear_n) begin
            tx_cnt_r <= 5'h00;
        end else if (link.converter_select_n) begin
            tx_cnt_r <= 5'h00;
        end else begin
            tx_cnt_r <= tx_cnt_r + 5'h01;
        end
    end
    // bit 31 drives from select fall so the first rising edge sees it
    always_comb begin
        miso_r = echo_r[5'h1f - tx_cnt_r];
    end
    assign link.miso = miso_r;

    // select rising ends the word: latch echo and run the command
    assign rx_w = shift_r;
    always_ff @(posedge link.converter_select_n
                or negedge link.converter_clear_n) begin
        if (!link.converter_clear_n) begin
            echo_r <= 32'h00000000;
            conv_r <= 1'b0;
            for (int i = 0; i < `QDAC_NUM_CH; i++) begin
                ch_r[i] <= '0;
            end
        end else begin
            echo_r <= rx_w;
            conv_r <= ~conv_r;
            if (rx_w[`QDAC_CMD_MSB:`QDAC_CMD_LSB] == `QDAC_CMD_UPDATE) begin
                for (int i = 0; i < `QDAC_NUM_CH; i++) begin
                    if (rx_w[`QDAC_ADDR_MSB:`QDAC_ADDR_LSB] == `QDAC_ADDR_ALL
                        || rx_w[`QDAC_ADDR_MSB:`QDAC_ADDR_LSB] == 4'(i))
                    begin
                        ch_r[i] <= rx_w[`QDAC_DATA_MSB:`QDAC_DATA_LSB];
                    end
                end
            end
        end
    end
    assign ch_a = ch_r[0];
    assign ch_b = ch_r[1];
    assign ch_c = ch_r[2];
    assign ch_d = ch_r[3];
    assign conv_start = conv_r;
endmodule : qdac_converter

// >>> verilog/qdac_master.sv
// master end: apb slave registers driving the serial command link
// Overview of operation
// - master clocks mosi, converter answers miso
// - select low active; rise starts conversion
// - clear low resets converter asynchronously
// - other bus devices held disabled
// - static link, clock up to 50 MHz
// - mosi shifted msb first after select
// - converter samples mosi on rising edges
// - miso changes falling, master samples rising
// - first miso sample on first rise
// - exactly 32 bits, then select high
// - 32-bit shift register echoes previous word
// - only the 32-bit protocol built
// - word: 8 pad, cmd, addr, data, 4 pad
// - command 0011 updates addressed outputs now
// - address selects one or all channels
// - echo check confirms communication
`timescale 1ns/10ps
`include "qdac_consts.svh"
module qdac_master #(
    parameter logic [7:0] DIV_HALF = `QDAC_DIV_HALF
) (
    input wire logic pclk,
    input wire logic presetn,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [11:0] paddr,
    input wire logic [31:0] pwdata,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    qdac_link_if.master link
);
    qdac_pkg::qdac_mst_state_t state_r;
    logic [7:0] div_r;
    logic [5:0] bit_r;
    logic [31:0] tx_r;
    logic [31:0] rx_r;
    logic [31:0] last_tx_r;
    logic [31:0] echo_r;
    logic [31:0] prev_tx_r;
    logic busy_r;
    logic done_r;
    logic echo_ok_r;
    logic clear_r;
    logic sck_r;
    logic cs_n_r;
    logic mosi_r;
    logic [31:0] prdata_r;
    logic miso_s;
    logic wr_en;
    logic rd_en;
    logic start;
    logic tick;

    qdac_sync #(.WIDTH(1)) u_miso_sync (
        .clk(pclk),
        .rst_n(presetn),
        .d(link.miso),
        .q(miso_s)
    );

    assign wr_en = psel && penable && pwrite;
    assign rd_en = psel && !penable && !pwrite;
    assign start = wr_en && paddr == `QDAC_REG_CTRL
                   && pwdata[`QDAC_CTRL_START] && !busy_r;
    assign tick = div_r == DIV_HALF;

    // registers answer in the first access cycle
    assign pready = 1'b1;
    assign pslverr = 1'b0;
    assign prdata = prdata_r;

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            prdata_r <= 32'h00000000;
        end else if (rd_en) begin
            case (paddr)
                `QDAC_REG_TXWORD: prdata_r <= last_tx_r;
                `QDAC_REG_STATUS: prdata_r <= {29'h00000000, echo_ok_r,
                                               done_r, busy_r};
                `QDAC_REG_ECHO: prdata_r <= echo_r;
                `QDAC_REG_CTRL: prdata_r <= {30'h00000000, clear_r, 1'b0};
                default: prdata_r <= 32'h00000000;
            endcase
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            last_tx_r <= 32'h00000000;
            clear_r <= 1'b1;
        end else if (wr_en) begin
            if (paddr == `QDAC_REG_TXWORD && !busy_r) begin
                last_tx_r <= pwdata;
            end
            if (paddr == `QDAC_REG_CTRL) begin
                clear_r <= pwdata[`QDAC_CTRL_CLEAR];
            end
        end
    end

    // clock divider: sck toggles every DIV_HALF+1 pclk cycles
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            div_r <= 8'h00;
        end else if (state_r == qdac_pkg::QDAC_IDLE || tick) begin
            div_r <= 8'h00;
        end else begin
            div_r <= div_r + 8'h01;
        end
    end

    // serial engine; at 20 MHz pclk the link runs far under 50 MHz
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            state_r <= qdac_pkg::QDAC_IDLE;
            bit_r <= 6'h00;
            tx_r <= 32'h00000000;
            rx_r <= 32'h00000000;
            sck_r <= 1'b0;
            cs_n_r <= 1'b1;
            mosi_r <= 1'b0;
            busy_r <= 1'b0;
        end else begin
            case (state_r)
                qdac_pkg::QDAC_IDLE: begin
                    if (start) begin
                        cs_n_r <= 1'b0;
                        mosi_r <= last_tx_r[31];
                        tx_r <= {last_tx_r[30:0], 1'b0};
                        bit_r <= 6'h00;
                        busy_r <= 1'b1;
                        state_r <= qdac_pkg::QDAC_LOW;
                    end
                end
                qdac_pkg::QDAC_LOW: begin
                    if (tick) begin
                        sck_r <= 1'b1;
                        bit_r <= bit_r + 6'h01;
                        state_r <= qdac_pkg::QDAC_HIGH;
                    end
                end
                qdac_pkg::QDAC_HIGH: begin
                    if (tick) begin
                        // miso_s lags two flops and miso moves only after
                        // a fall, so this is the bit that stood at the rise;
                        // needs DIV_HALF of 1 or more
                        rx_r <= {rx_r[30:0], miso_s};
                        sck_r <= 1'b0;
                        if (bit_r == 6'(`QDAC_WORD_BITS)) begin
                            state_r <= qdac_pkg::QDAC_END;
                        end else begin
                            mosi_r <= tx_r[31];
                            tx_r <= {tx_r[30:0], 1'b0};
                            state_r <= qdac_pkg::QDAC_LOW;
                        end
                    end
                end
                qdac_pkg::QDAC_END: begin
                    if (tick) begin
                        cs_n_r <= 1'b1;
                        busy_r <= 1'b0;
                        state_r <= qdac_pkg::QDAC_IDLE;
                    end
                end
                default: state_r <= qdac_pkg::QDAC_IDLE;
            endcase
        end
    end

    // done is sticky until the next start
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            done_r <= 1'b0;
            echo_r <= 32'h00000000;
            echo_ok_r <= 1'b0;
            prev_tx_r <= 32'h00000000;
        end else if (state_r == qdac_pkg::QDAC_END && tick) begin
            done_r <= 1'b1;
            echo_r <= rx_r;
            // the converter echoes the word sent before this one
            echo_ok_r <= rx_r == prev_tx_r;
            prev_tx_r <= last_tx_r;
        end else begin
            if (start) begin
                done_r <= 1'b0;
            end
            // a cleared converter echoes zero on the next word
            if (!clear_r) begin
                prev_tx_r <= 32'h00000000;
            end
        end
    end

    // mosi/sck/select all registered; bus devices kept off
    assign link.serial_clk = sck_r;
    assign link.mosi = mosi_r;
    assign link.converter_select_n = cs_n_r;
    assign link.converter_clear_n = clear_r;
    assign link.serial_flash_select_n = 1'b1;
    assign link.preamp_select_n = 1'b1;
    assign link.adc_convert_strobe = 1'b0;
    assign link.parallel_flash_chip_enable_n = 1'b1;
    assign link.config_prom_init_n = 1'b0;
endmodule : qdac_master

// >>> testbench/qdac_link_props.sv
// wire checks for the quad converter command link
`timescale 1ns/10ps
module qdac_link_props (
    input wire logic pclk,
    input wire logic presetn,
    input wire logic serial_clk,
    input wire logic mosi,
    input wire logic miso,
    input wire logic converter_select_n,
    input wire logic converter_clear_n,
    input wire logic serial_flash_select_n,
    input wire logic preamp_select_n,
    input wire logic adc_convert_strobe,
    input wire logic parallel_flash_chip_enable_n,
    input wire logic config_prom_init_n
);
    logic sck_r;
    logic [5:0] rise_r;
    default clocking @(posedge pclk); endclocking
    default disable iff (!presetn);
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn)
            sck_r <= 1'b0;
        else
            sck_r <= serial_clk;
    end
    // rising edges seen in the current word
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn)
            rise_r <= 6'h00;
        else if (converter_select_n)
            rise_r <= 6'h00;
        else if (serial_clk && !sck_r)
            rise_r <= rise_r + 6'h01;
    end
    a_others_off: assert property (
        serial_flash_select_n && preamp_select_n
        && !adc_convert_strobe && parallel_flash_chip_enable_n
        && !config_prom_init_n) else $error("shared bus device enabled");
    a_sck_idle: assert property (
        converter_select_n |-> !serial_clk)
        else $error("clock runs while deselected");
    a_bit_count: assert property (
        $rose(converter_select_n) |-> rise_r == 6'h20)
        else $error("word not 32 bits");
    a_mosi_hold: assert property (
        $rose(serial_clk) |-> $stable(mosi))
        else $error("mosi moved at rising edge");
    a_mosi_fall: assert property (
        !converter_select_n && !$past(converter_select_n)
        && $changed(mosi) |-> $fell(serial_clk))
        else $error("mosi off falling");
    a_miso_fall: assert property (
        !converter_select_n && !$past(converter_select_n)
        && $changed(miso) |-> $fell(serial_clk))
        else $error("miso off falling");
    a_half_period: assert property (
        $rose(serial_clk) |=> serial_clk ##1 !serial_clk)
        else $error("bad clock half period");
    a_first_rise: assert property (
        $fell(converter_select_n) |-> !serial_clk ##2 serial_clk)
        else $error("late first rising edge");
    a_clear_miso: assert property (
        !converter_clear_n |=> !miso)
        else $error("miso not cleared");
    c_word: cover property ($rose(converter_select_n));
    c_start: cover property ($fell(converter_select_n));
    c_clear: cover property ($fell(converter_clear_n));
endmodule : qdac_link_props

// >>> testbench/tb.sv
// self-checking bench for the quad converter command link
`timescale 1ns/10ps
`include "qdac_consts.svh"
`define CHK(a, e) begin cmp_count++; if ((a) !== (e)) begin fails++; \
    $display("wrong value t=%0t got %h exp %h", $time, a, e); end end
module tb;
    logic pclk = 1'b0;
    logic presetn = 1'b0;
    logic psel = 1'b0;
    logic penable = 1'b0;
    logic pwrite = 1'b0;
    logic [11:0] paddr = 12'h000;
    logic [31:0] pwdata = 32'h00000000;
    logic [31:0] prdata;
    logic pready;
    logic conv_start;
    logic [11:0] ch[4];
    logic [11:0] exp_ch[4];
    logic [31:0] prev;
    logic [31:0] rd;
    int fails = 0;
    int cmp_count = 0;
    int cyc = 0;
    integer seed = 32'h7d0c;
    qdac_link_if link_if ();
    qdac_master qdac_master_inst (.pclk(pclk), .presetn(presetn),
        .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
        .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(),
        .link(link_if));
    qdac_converter qdac_converter_inst (.link(link_if), .ch_a(ch[0]),
        .ch_b(ch[1]), .ch_c(ch[2]), .ch_d(ch[3]), .conv_start(conv_start));
    qdac_link_props props_inst (.pclk(pclk), .presetn(presetn),
        .serial_clk(link_if.serial_clk), .mosi(link_if.mosi),
        .miso(link_if.miso), .converter_select_n(link_if.converter_select_n),
        .converter_clear_n(link_if.converter_clear_n),
        .serial_flash_select_n(link_if.serial_flash_select_n),
        .preamp_select_n(link_if.preamp_select_n),
        .adc_convert_strobe(link_if.adc_convert_strobe),
        .parallel_flash_chip_enable_n(link_if.parallel_flash_chip_enable_n),
        .config_prom_init_n(link_if.config_prom_init_n));
    always #25 pclk = ~pclk;
    always @(posedge pclk) begin
        cyc++;
        if (cyc == 30000) begin
            fails++;
            results();
        end
    end
    task automatic results();
        $display("checks %0d mismatches %0d", cmp_count, fails);
        if (fails == 0 && cmp_count > 0)
            $display("*** PASS ***");
        else
            $display("*** FAIL ***");
        $finish;
    endtask : results
    task automatic apb(input logic wr, input logic [11:0] a,
        input logic [31:0] d);
        psel <= 1'b1;
        pwrite <= wr;
        paddr <= a;
        pwdata <= d;
        @(posedge pclk);
        penable <= 1'b1;
        @(posedge pclk);
        while (pready !== 1'b1) @(posedge pclk);
        rd = prdata;
        psel <= 1'b0;
        penable <= 1'b0;
        @(posedge pclk);
    endtask : apb
    // clear pulse; clear_n bit kept high otherwise
    task automatic clear();
        apb(1'b1, `QDAC_REG_CTRL, 32'h00000000);
        apb(1'b1, `QDAC_REG_CTRL, 32'h00000002);
        apb(1'b0, `QDAC_REG_CTRL, 32'h00000000);
        `CHK(rd, 32'h00000002)
        prev = 32'h00000000;
        for (int i = 0; i < 4; i++) begin
            exp_ch[i] = 12'h000;
            `CHK(ch[i], exp_ch[i])
        end
    endtask : clear
    // does an update word with this address reach channel i
    function automatic logic hits(input logic [3:0] cmd,
        input logic [3:0] ad, input int i);
        return cmd == `QDAC_CMD_UPDATE
            && (ad == `QDAC_ADDR_ALL || ad == 4'(i));
    endfunction : hits
    task automatic send(input logic [3:0] cmd, input logic [3:0] ad,
        input logic [11:0] v);
        logic [31:0] w;
        logic cs0;
        int n;
        w = {8'($random(seed)), cmd, ad, v, 4'($random(seed))};
        cs0 = conv_start;
        apb(1'b1, `QDAC_REG_TXWORD, w);
        apb(1'b1, `QDAC_REG_CTRL, 32'h00000003);
        apb(1'b0, `QDAC_REG_STATUS, 32'h00000000);
        `CHK(rd[1:0], 2'h1)
        // must be refused while the word is on the wire
        apb(1'b1, `QDAC_REG_TXWORD, ~w);
        n = 0;
        do begin
            apb(1'b0, `QDAC_REG_STATUS, 32'h00000000);
            n++;
        end while (rd[1] !== 1'b1 && n < 100);
        `CHK(rd[1], 1'b1)
        `CHK(rd[2], 1'b1)
        apb(1'b0, `QDAC_REG_ECHO, 32'h00000000);
        `CHK(rd, prev)
        apb(1'b0, `QDAC_REG_TXWORD, 32'h00000000);
        `CHK(rd, w)
        prev = w;
        for (int i = 0; i < 4; i++)
            if (hits(cmd, ad, i))
                exp_ch[i] = v;
        for (int i = 0; i < 4; i++)
            `CHK(ch[i], exp_ch[i])
        `CHK(conv_start, ~cs0)
    endtask : send
    initial begin
        repeat (6) @(posedge pclk);
        presetn <= 1'b1;
        @(posedge pclk);
        apb(1'b0, 12'h010, 32'h00000000);
        `CHK(rd, 32'h00000000)
        clear();
        for (int a = 0; a < 16; a++)
            send(4'h3, 4'(a), 12'($random(seed)));
        send(4'h3, 4'hf, 12'hfff);
        send(4'h3, 4'h0, 12'h000);
        repeat (12) send(4'($random(seed)), 4'($random(seed)),
            12'($random(seed)));
        clear();
        send(4'h3, 4'hf, 12'h5a5);
        results();
    end
endmodule : tb
